// ==== hdl/spi_irq_crc.sv ====
// spi interrupt enable/status/clear, partial byte lengths and serial crc engine
// assumes an axi4-lite master on aclk, a shift engine and fifos on aclk driving the
// event inputs, and raw link pins (clock and both data lines) from outside the domain
`timescale 1ns/1ps
`default_nettype none

module spi_irq_crc #(
	parameter int unsigned ADDR_W = spi_irq_crc_pkg::ADDR_W
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic tx_fifo_empty,
	input wire logic rx_fifo_full,
	input wire logic tx_underflow_event,
	input wire logic rx_overflow_event,
	input wire logic rx_byte_irq,
	input wire logic tx_byte_irq,
	input wire logic block_done_irq,
	input wire logic rx_data_read,
	input wire logic link_sck,
	input wire logic link_tx_data,
	input wire logic link_rx_data,
	output logic fifo_init,
	output logic full_duplex,
	output logic [3:0] tx_bit_count,
	output logic [3:0] rx_bit_count,
	output logic spi_irq
);

	// write channel holding registers, taken in either order
	logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
	logic [ADDR_W-1:0] aw_addr_q;
	logic [15:0] w_data_q;
	logic [1:0] w_strb_q;
	logic [1:0] bresp_q, rresp_q;
	logic [31:0] rdata_q;
	// register state
	logic full_duplex_q, fifo_init_q, irq_q;
	logic [2:0] tx_len_q, rx_len_q, ien_q;
	logic [3:0] tx_cnt_q, rx_cnt_q;
	logic rx_flag_q, tx_flag_q, blk_flag_q, fifo_err_q;
	logic [1:0] crc_sel_q;
	logic crc_en_q, crc_rx_src_q;
	logic [15:0] crc_q, crc_d;
	// link synchronisers
	logic sck_s1_q, sck_s2_q, sck_s3_q, txd_s1_q, txd_s2_q, rxd_s1_q, rxd_s2_q;

	// write decode
	wire wr_fire = !awready_q && !wready_q && !bvalid_q;
	wire [ADDR_W-1:0] wr_word = aw_addr_q >> spi_irq_crc_pkg::WORD_LSB;
	wire wr_ctl = wr_fire && (wr_word == ADDR_W'(spi_irq_crc_pkg::CONTROL_IDX));
	wire wr_ien = wr_fire && (wr_word == ADDR_W'(spi_irq_crc_pkg::IRQ_ENABLE_IDX));
	wire wr_sts = wr_fire && (wr_word == ADDR_W'(spi_irq_crc_pkg::IRQ_STATUS_IDX));
	wire wr_clr = wr_fire && (wr_word == ADDR_W'(spi_irq_crc_pkg::IRQ_CLEAR_IDX));
	wire wr_crcc = wr_fire && (wr_word == ADDR_W'(spi_irq_crc_pkg::CRC_CONTROL_IDX));
	wire wr_crcv = wr_fire && (wr_word == ADDR_W'(spi_irq_crc_pkg::CRC_VALUE_IDX));
	wire wr_hit = wr_ctl || wr_ien || wr_sts || wr_clr || wr_crcc || wr_crcv;
	wire lo_en = w_strb_q[0];
	wire hi_en = w_strb_q[1];
	wire [15:0] wmask = {{8{hi_en}}, {8{lo_en}}};

	// pulse bits act only when their byte lane is written
	wire init_req = wr_ctl && hi_en && w_data_q[spi_irq_crc_pkg::CTL_FIFO_INIT];
	wire tx_clr_req = wr_clr && lo_en && w_data_q[spi_irq_crc_pkg::IRQ_TX];
	wire blk_clr_req = wr_clr && lo_en && w_data_q[spi_irq_crc_pkg::IRQ_BLOCK];
	wire crc_clr_req = wr_crcc && hi_en && w_data_q[spi_irq_crc_pkg::CRC_CLEAR];

	// read decode
	wire rd_fire = s_axi_arvalid && arready_q;
	wire [ADDR_W-1:0] rd_word = s_axi_araddr >> spi_irq_crc_pkg::WORD_LSB;
	wire rd_ctl = rd_word == ADDR_W'(spi_irq_crc_pkg::CONTROL_IDX);
	wire rd_ien = rd_word == ADDR_W'(spi_irq_crc_pkg::IRQ_ENABLE_IDX);
	wire rd_sts = rd_word == ADDR_W'(spi_irq_crc_pkg::IRQ_STATUS_IDX);
	wire rd_clr = rd_word == ADDR_W'(spi_irq_crc_pkg::IRQ_CLEAR_IDX);
	wire rd_crcc = rd_word == ADDR_W'(spi_irq_crc_pkg::CRC_CONTROL_IDX);
	wire rd_crcv = rd_word == ADDR_W'(spi_irq_crc_pkg::CRC_VALUE_IDX);
	wire rd_hit = rd_ctl || rd_ien || rd_sts || rd_clr || rd_crcc || rd_crcv;

	// crc flags; in crc7 mode only the low seven bits count
	wire crc7 = crc_sel_q == spi_irq_crc_pkg::CRC_CRC7;
	wire crc_nonzero = crc7 ? (crc_q[6:0] != 7'h00) : (crc_q != 16'h0000);
	wire crc_not_ones = crc7 ? (crc_q[6:0] != spi_irq_crc_pkg::CRC7_ONES)
		: (crc_q != spi_irq_crc_pkg::CRC_RESET);

	// read views of each register; the clear register reads zero
	wire [15:0] ctl_view = {1'b0, 1'b0, 1'b0, full_duplex_q, 4'h0, tx_fifo_empty,
		rx_fifo_full, tx_len_q, rx_len_q};
	wire [15:0] ien_view = {13'h0000, ien_q};
	wire [15:0] sts_view = {8'h00, fifo_err_q, 4'h0, rx_flag_q, tx_flag_q, blk_flag_q};
	wire [15:0] crcc_view = {crc_sel_q, crc_en_q, 1'b0, crc_rx_src_q, crc_nonzero,
		crc_not_ones, 9'h000};
	wire [15:0] rd_view = rd_ctl ? ctl_view : rd_ien ? ien_view : rd_sts ? sts_view
		: rd_crcc ? crcc_view : rd_crcv ? crc_q : 16'h0000;

	// write address and data channels, each held once taken until both are in and the response is gone
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_q <= 1'b1;
			wready_q <= 1'b1;
			aw_addr_q <= '0;
			w_data_q <= 16'h0000;
			w_strb_q <= 2'h0;
		end else if (wr_fire) begin
			awready_q <= 1'b1;
			wready_q <= 1'b1;
		end else begin
			if (s_axi_awvalid && awready_q) begin
				awready_q <= 1'b0;
				aw_addr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && wready_q) begin
				wready_q <= 1'b0;
				w_data_q <= s_axi_wdata[15:0];
				w_strb_q <= s_axi_wstrb[1:0];
			end
		end
	end

	// write response, slave error for an unmapped word
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_q <= 1'b0;
			bresp_q <= spi_irq_crc_pkg::RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_q <= 1'b1;
			bresp_q <= wr_hit ? spi_irq_crc_pkg::RESP_OKAY : spi_irq_crc_pkg::RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_q <= 1'b0;
		end
	end

	// read channel, one read under way at a time
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_q <= 1'b1;
			rvalid_q <= 1'b0;
			rdata_q <= 32'h00000000;
			rresp_q <= spi_irq_crc_pkg::RESP_OKAY;
		end else if (rd_fire) begin
			arready_q <= 1'b0;
			rvalid_q <= 1'b1;
			rdata_q <= {16'h0000, rd_view};
			rresp_q <= rd_hit ? spi_irq_crc_pkg::RESP_OKAY : spi_irq_crc_pkg::RESP_SLVERR;
		end else if (rvalid_q && s_axi_rready) begin
			arready_q <= 1'b1;
			rvalid_q <= 1'b0;
		end
	end

	// control fields and the self-clearing fifo init pulse
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			full_duplex_q <= 1'b0;
			tx_len_q <= 3'h0;
			rx_len_q <= 3'h0;
			fifo_init_q <= 1'b0;
		end else begin
			fifo_init_q <= init_req;
			if (wr_ctl && hi_en) begin
				full_duplex_q <= w_data_q[spi_irq_crc_pkg::CTL_FULL_DUPLEX];
			end
			if (wr_ctl && lo_en) begin
				tx_len_q <= w_data_q[spi_irq_crc_pkg::CTL_TX_LEN_LSB +: spi_irq_crc_pkg::LEN_W];
				rx_len_q <= w_data_q[spi_irq_crc_pkg::CTL_RX_LEN_LSB +: spi_irq_crc_pkg::LEN_W];
			end
		end
	end

	// bit counts handed to the shift engine; zero means a whole byte
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tx_cnt_q <= spi_irq_crc_pkg::FULL_BYTE_BITS;
			rx_cnt_q <= spi_irq_crc_pkg::FULL_BYTE_BITS;
		end else begin
			tx_cnt_q <= (tx_len_q == 3'h0) ? spi_irq_crc_pkg::FULL_BYTE_BITS : {1'b0, tx_len_q};
			rx_cnt_q <= (rx_len_q == 3'h0) ? spi_irq_crc_pkg::FULL_BYTE_BITS : {1'b0, rx_len_q};
		end
	end

	// interrupt enables; the status register has no write path at all
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ien_q <= 3'h0;
		end else if (wr_ien && lo_en) begin
			ien_q <= w_data_q[2:0];
		end
	end

	// sticky flags; a new event wins over a clear in the same cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rx_flag_q <= 1'b0;
			tx_flag_q <= 1'b0;
			blk_flag_q <= 1'b0;
			fifo_err_q <= 1'b0;
		end else begin
			rx_flag_q <= rx_byte_irq || (rx_flag_q && !rx_data_read);
			tx_flag_q <= tx_byte_irq || (tx_flag_q && !tx_clr_req);
			blk_flag_q <= block_done_irq || (blk_flag_q && !blk_clr_req);
			fifo_err_q <= tx_underflow_event || rx_overflow_event
				|| (fifo_err_q && !init_req);
		end
	end

	// one request line for all enabled flags
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= (rx_flag_q && ien_q[spi_irq_crc_pkg::IRQ_RX])
				|| (tx_flag_q && ien_q[spi_irq_crc_pkg::IRQ_TX])
				|| (blk_flag_q && ien_q[spi_irq_crc_pkg::IRQ_BLOCK]);
		end
	end

	// link pins through two flops; the third stage only finds the clock edge
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sck_s1_q <= 1'b0;
			sck_s2_q <= 1'b0;
			sck_s3_q <= 1'b0;
			txd_s1_q <= 1'b0;
			txd_s2_q <= 1'b0;
			rxd_s1_q <= 1'b0;
			rxd_s2_q <= 1'b0;
		end else begin
			sck_s1_q <= link_sck;
			sck_s2_q <= sck_s1_q;
			sck_s3_q <= sck_s2_q;
			txd_s1_q <= link_tx_data;
			txd_s2_q <= txd_s1_q;
			rxd_s1_q <= link_rx_data;
			rxd_s2_q <= rxd_s1_q;
		end
	end

	// crc input bit: stream choice only matters in full duplex
	wire sck_rise = sck_s2_q && !sck_s3_q;
	wire crc_bit = (full_duplex_q && !crc_rx_src_q) ? txd_s2_q : rxd_s2_q;
	wire crc_step = crc_en_q && sck_rise;
	wire fb16 = crc_bit ^ crc_q[15];
	wire fb7 = crc_bit ^ crc_q[6];

	// one serial crc step per sampled rising link clock edge
	always_comb begin
		crc_d = crc_q;
		case (spi_irq_crc_pkg::crc_sel_type'(crc_sel_q))
			spi_irq_crc_pkg::CRC_MMC16: begin
				crc_d = {crc_q[14:0], 1'b0} ^ (fb16 ? spi_irq_crc_pkg::POLY_MMC16 : 16'h0000);
			end
			spi_irq_crc_pkg::CRC_CRC7: begin
				crc_d[6:0] = {crc_q[5:0], 1'b0} ^ (fb7 ? spi_irq_crc_pkg::POLY_CRC7 : 7'h00);
			end
			spi_irq_crc_pkg::CRC_MST16: begin
				crc_d = {crc_q[14:0], 1'b0} ^ (fb16 ? spi_irq_crc_pkg::POLY_MST16 : 16'h0000);
			end
			default: begin
				crc_d = {crc_q[14:0], 1'b0} ^ (fb16 ? spi_irq_crc_pkg::POLY_RSVD16 : 16'h0000);
			end
		endcase
	end

	// crc control fields
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			crc_sel_q <= 2'h0;
			crc_en_q <= 1'b0;
			crc_rx_src_q <= 1'b0;
		end else if (wr_crcc && hi_en) begin
			crc_sel_q <= w_data_q[spi_irq_crc_pkg::CRC_SEL_LSB +: 2];
			crc_en_q <= w_data_q[spi_irq_crc_pkg::CRC_ENABLE];
			crc_rx_src_q <= w_data_q[spi_irq_crc_pkg::CRC_RX_SRC];
		end
	end

	// crc value: clear beats a direct write, which beats a step
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			crc_q <= spi_irq_crc_pkg::CRC_RESET;
		end else if (crc_clr_req) begin
			crc_q <= spi_irq_crc_pkg::CRC_RESET;
		end else if (wr_crcv) begin
			crc_q <= (crc_q & ~wmask) | (w_data_q & wmask);
		end else if (crc_step) begin
			crc_q <= crc_d;
		end
	end

	// outputs
	assign s_axi_awready = awready_q;
	assign s_axi_wready = wready_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_arready = arready_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;
	assign fifo_init = fifo_init_q;
	assign full_duplex = full_duplex_q;
	assign tx_bit_count = tx_cnt_q;
	assign rx_bit_count = rx_cnt_q;
	assign spi_irq = irq_q;

	// checks
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_rx_full_read;
		rd_fire && rd_ctl |=> s_axi_rdata[spi_irq_crc_pkg::CTL_RX_FULL] == $past(rx_fifo_full);
	endproperty
	a_rx_full_read: assert property (p_rx_full_read) else $error("receive full bit wrong");
	property p_tx_count;
		tx_len_q == 3'h0 |=> tx_bit_count == spi_irq_crc_pkg::FULL_BYTE_BITS;
	endproperty
	a_tx_count: assert property (p_tx_count) else $error("tx length zero not eight");
	property p_rx_count;
		rx_len_q != 3'h0 |=> rx_bit_count == {1'b0, $past(rx_len_q)};
	endproperty
	a_rx_count: assert property (p_rx_count) else $error("rx partial count wrong");
	property p_masked_irq;
		ien_q == 3'h0 ##1 ien_q == 3'h0 |=> !spi_irq;
	endproperty
	a_masked_irq: assert property (p_masked_irq) else $error("irq while all disabled");
	property p_rx_irq;
		rx_byte_irq && ien_q[spi_irq_crc_pkg::IRQ_RX] && !wr_ien |-> ##2 spi_irq;
	endproperty
	a_rx_irq: assert property (p_rx_irq) else $error("enabled rx irq missing");
	property p_underflow;
		tx_underflow_event |=> fifo_err_q;
	endproperty
	a_underflow: assert property (p_underflow) else $error("underflow not flagged");
	property p_init_clears;
		init_req && !tx_underflow_event && !rx_overflow_event |=> !fifo_err_q;
	endproperty
	a_init_clears: assert property (p_init_clears) else $error("fifo init kept error");
	property p_tx_clear;
		tx_clr_req && !tx_byte_irq |=> !tx_flag_q ##1 (tx_flag_q == $past(tx_byte_irq));
	endproperty
	a_tx_clear: assert property (p_tx_clear) else $error("tx flag not cleared");
	property p_crc_idle;
		!crc_en_q && !crc_clr_req && !wr_crcv |=> $stable(crc_q);
	endproperty
	a_crc_idle: assert property (p_crc_idle) else $error("crc moved while disabled");
	property p_crc_clear;
		crc_clr_req |=> crc_q == spi_irq_crc_pkg::CRC_RESET;
	endproperty
	a_crc_clear: assert property (p_crc_clear) else $error("crc clear not all ones");

	c_write_read: cover property (wr_fire ##[1:8] rd_fire);
	c_crc_steps: cover property (crc_step ##[1:300] crc_step);
	c_irq_raised: cover property (!spi_irq ##1 spi_irq);

endmodule

`default_nettype wire

// ==== hdl/spi_irq_crc_pkg.sv ====
// constants shared by the spi interrupt, status and crc register block
// assumes a 32-bit axi4-lite register bus and 16-bit registers in the low half of each word
package spi_irq_crc_pkg;

	// register indices as printed; the byte address is four times the index
	localparam logic [15:0] CONTROL_IDX = 16'hc0ca;
	localparam logic [15:0] IRQ_ENABLE_IDX = 16'hc0cc;
	localparam logic [15:0] IRQ_STATUS_IDX = 16'hc0ce;
	localparam logic [15:0] IRQ_CLEAR_IDX = 16'hc0d0;
	localparam logic [15:0] CRC_CONTROL_IDX = 16'hc0d2;
	localparam logic [15:0] CRC_VALUE_IDX = 16'hc0d4;
	localparam int unsigned ADDR_W = 20;
	localparam int unsigned WORD_LSB = 2;

	// control register fields
	localparam int unsigned CTL_FIFO_INIT = 14;
	localparam int unsigned CTL_FULL_DUPLEX = 12;
	localparam int unsigned CTL_TX_EMPTY = 7;
	localparam int unsigned CTL_RX_FULL = 6;
	localparam int unsigned CTL_TX_LEN_LSB = 3;
	localparam int unsigned CTL_RX_LEN_LSB = 0;
	localparam int unsigned LEN_W = 3;
	localparam int unsigned COUNT_W = 4;
	localparam logic [3:0] FULL_BYTE_BITS = 4'h8;

	// interrupt enable, status and clear fields
	localparam int unsigned IRQ_RX = 2;
	localparam int unsigned IRQ_TX = 1;
	localparam int unsigned IRQ_BLOCK = 0;
	localparam int unsigned STS_FIFO_ERR = 7;

	// crc control fields
	localparam int unsigned CRC_SEL_LSB = 14;
	localparam int unsigned CRC_ENABLE = 13;
	localparam int unsigned CRC_CLEAR = 12;
	localparam int unsigned CRC_RX_SRC = 11;
	localparam int unsigned CRC_NONZERO = 10;
	localparam int unsigned CRC_NOT_ONES = 9;

	// crc polynomial choices and their feedback taps
	typedef enum logic [1:0] {
		CRC_MMC16 = 2'h0,
		CRC_CRC7 = 2'h1,
		CRC_MST16 = 2'h2,
		CRC_RSVD16 = 2'h3
	} crc_sel_type;
	localparam logic [15:0] POLY_MMC16 = 16'h1021;
	localparam logic [6:0] POLY_CRC7 = 7'h09;
	localparam logic [15:0] POLY_MST16 = 16'h8005;
	localparam logic [15:0] POLY_RSVD16 = 16'h0001;
	localparam logic [15:0] CRC_RESET = 16'hffff;
	localparam logic [6:0] CRC7_ONES = 7'h7f;

	// axi response codes
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ==== verif/spi_far_end.sv ====
// far-side spi model: drives the serial clock and both data lines of a frame
// assumes the block samples these pins on its own clock, unrelated in phase
`timescale 1ns/1ps
`default_nettype none

module spi_far_end (
	output var logic link_sck,
	output var logic link_tx_data,
	output var logic link_rx_data
);
	// idle lines: clock stands low between frames
	initial begin
		link_sck = 1'b0;
		link_tx_data = 1'b0;
		link_rx_data = 1'b1;
	end

	// one frame, msb first, 200 ns clock; data changes only while the clock is low
	task automatic send(input logic [7:0] rxb, input logic [7:0] txb, input int n);
		#5; // keep every pin change off the block's clock edges
		for (int i = n - 1; i >= 0; i--) begin
			link_rx_data = rxb[i];
			link_tx_data = txb[i];
			#100;
			link_sck = 1'b1;
			#100;
			link_sck = 1'b0;
		end
		// released lines flip, so a stale bit can never pass for a sampled one
		link_rx_data = ~link_rx_data;
		link_tx_data = ~link_tx_data;
	endtask
endmodule

`default_nettype wire

// ==== verif/tb_spi_irq_crc.sv ====
// self-checking bench for the spi interrupt, status and crc register block
// assumes the block, its package and the far-side model are compiled first
`timescale 1ns/1ps
`default_nettype none

module tb_spi_irq_crc;
	typedef struct {logic [31:0] d; logic [31:0] m; logic [1:0] r;} note_type;
	logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic [19:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb, tx_bit_count, rx_bit_count;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic tx_fifo_empty, rx_fifo_full, tx_underflow_event, rx_overflow_event;
	logic rx_byte_irq, tx_byte_irq, block_done_irq, rx_data_read;
	logic link_sck, link_tx_data, link_rx_data, fifo_init, full_duplex, spi_irq;
	logic [5:0] ev;
	logic [31:0] seed = 32'h2eec5464;
	int bad_count = 0;
	int num_checks = 0;
	int init_seen = 0;
	note_type notes[$];
	note_type cur;

	assign {rx_data_read, rx_overflow_event, tx_underflow_event, rx_byte_irq, tx_byte_irq,
		block_done_irq} = ev;

	spi_irq_crc i_spi_irq_crc (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0),
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .tx_fifo_empty, .rx_fifo_full, .tx_underflow_event,
		.rx_overflow_event, .rx_byte_irq, .tx_byte_irq, .block_done_irq, .rx_data_read,
		.link_sck, .link_tx_data, .link_rx_data, .fifo_init, .full_duplex, .tx_bit_count,
		.rx_bit_count, .spi_irq);

	spi_far_end i_spi_far_end (.link_sck, .link_tx_data, .link_rx_data);

	// 40 mhz bench clock
	initial begin
		aclk = 1'b0;
		forever #12.5 aclk = ~aclk;
	end

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// serial crc, msb first, on the stream the block should pick
	function automatic logic [15:0] crc_bits(input logic [15:0] c, input logic [7:0] s,
			input logic [1:0] m);
		logic fb;
		for (int i = 7; i >= 0; i--) begin
			fb = s[i] ^ ((m == 2'h1) ? c[6] : c[15]);
			if (m == 2'h1) c[6:0] = {c[5:0], 1'b0} ^ (fb ? 7'h09 : 7'h00);
			else c = {c[14:0], 1'b0} ^ (fb ? ((m == 2'h0) ? 16'h1021 :
				(m == 2'h2) ? 16'h8005 : 16'h0001) : 16'h0000);
		end
		return c;
	endfunction

	// axi write: address and data offered together, each released once taken
	task automatic wr(input logic [15:0] idx, input logic [15:0] d, input logic [1:0] r = 2'h0);
		logic aw_done, w_done;
		aw_done = 1'b0;
		w_done = 1'b0;
		s_axi_awaddr <= 20'({idx, 2'b00});
		s_axi_wdata <= {16'h0000, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		while (!(aw_done && w_done)) begin
			@(posedge aclk);
			if (s_axi_awready && !aw_done) begin
				aw_done = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (s_axi_wready && !w_done) begin
				w_done = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
		check("bresp", 32'(s_axi_bresp), 32'(r));
	endtask

	// axi read: the expectation is noted first, the monitor compares the answer
	task automatic rd(input logic [15:0] idx, input logic [31:0] d,
			input logic [31:0] m = 32'hffff, input logic [1:0] r = 2'h0);
		notes.push_back('{d, m, r});
		s_axi_araddr <= 20'({idx, 2'b00});
		s_axi_arvalid <= 1'b1;
		do @(posedge aclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
	endtask

	task automatic pulse(input logic [5:0] p);
		ev <= p;
		@(posedge aclk);
		ev <= 6'h00;
		@(posedge aclk);
	endtask

	// read monitor and fifo init pulse counter
	always @(posedge aclk) begin
		if (fifo_init === 1'b1) init_seen++;
		if (s_axi_rvalid === 1'b1 && s_axi_rready && notes.size() > 0) begin
			cur = notes.pop_front();
			check("rdata", s_axi_rdata & cur.m, cur.d);
			check("rresp", 32'(s_axi_rresp), 32'(cur.r));
		end
	end

	// watchdog well beyond the expected run length
	initial begin
		#400000;
		bad_count++;
		report_and_stop();
	end

	initial begin
		logic [31:0] r;
		logic [15:0] c, mk;
		logic [1:0] m;
		aresetn = 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, rx_fifo_full} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, ev} = '0;
		{s_axi_bready, s_axi_rready, tx_fifo_empty} = 3'h7;
		s_axi_wstrb = 4'h3;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(spi_irq_crc_pkg::IRQ_ENABLE_IDX, 32'h0);
		rd(spi_irq_crc_pkg::IRQ_STATUS_IDX, 32'h0);
		rd(spi_irq_crc_pkg::IRQ_CLEAR_IDX, 32'h0);
		rd(spi_irq_crc_pkg::CRC_CONTROL_IDX, 32'h0400);
		rd(spi_irq_crc_pkg::CONTROL_IDX, 32'h80, 32'hc0);
		rd(16'h0100, 32'h0, 32'hffffffff, 2'h2);
		wr(16'h0100, 16'h0007, 2'h2);
		// every transmit and receive length code
		for (int v = 0; v < 8; v++) begin
			wr(spi_irq_crc_pkg::CONTROL_IDX, 16'((v << 3) | (7 - v)));
			@(posedge aclk);
			check("tx_bits", 32'(tx_bit_count), (v == 0) ? 32'h8 : 32'(v));
			check("rx_bits", 32'(rx_bit_count), (v == 7) ? 32'h8 : 32'(7 - v));
		end
		// each interrupt flag: suppressed, enabled, cleared
		for (int i = 0; i < 3; i++) begin
			pulse(6'(1 << i));
			repeat (3) @(posedge aclk);
			check("irq_off", 32'(spi_irq), 32'h0);
			wr(spi_irq_crc_pkg::IRQ_STATUS_IDX, 16'hffff);
			wr(spi_irq_crc_pkg::IRQ_CLEAR_IDX, 16'h0000);
			rd(spi_irq_crc_pkg::IRQ_STATUS_IDX, 32'(1 << i));
			wr(spi_irq_crc_pkg::IRQ_ENABLE_IDX, 16'(1 << i));
			repeat (3) @(posedge aclk);
			check("irq_on", 32'(spi_irq), 32'h1);
			pulse(6'(1 << i));
			if (i == 2) pulse(6'h20);
			else wr(spi_irq_crc_pkg::IRQ_CLEAR_IDX, 16'(1 << i));
			repeat (3) @(posedge aclk);
			check("irq_clr", 32'(spi_irq), 32'h0);
			rd(spi_irq_crc_pkg::IRQ_STATUS_IDX, 32'h0);
			wr(spi_irq_crc_pkg::IRQ_ENABLE_IDX, 16'h0000);
		end
		// fifo error from underflow, cleared by fifo init, then from overflow
		pulse(6'h08);
		rd(spi_irq_crc_pkg::IRQ_STATUS_IDX, 32'h80);
		wr(spi_irq_crc_pkg::CONTROL_IDX, 16'h4000);
		rd(spi_irq_crc_pkg::IRQ_STATUS_IDX, 32'h0);
		check("init", 32'(init_seen), 32'h1);
		tx_fifo_empty <= 1'b0;
		rx_fifo_full <= 1'b1;
		pulse(6'h10);
		rd(spi_irq_crc_pkg::IRQ_STATUS_IDX, 32'h80);
		rd(spi_irq_crc_pkg::CONTROL_IDX, 32'h40, 32'hc0);
		// every crc mode, duplex and stream choice over one random frame each
		for (int k = 0; k < 4; k++) begin
			m = 2'(k);
			wr(spi_irq_crc_pkg::CONTROL_IDX, {3'h0, m[0], 12'h000});
			check("duplex", 32'(full_duplex), 32'(m[0]));
			wr(spi_irq_crc_pkg::CRC_CONTROL_IDX, {m, 2'h3, m[1], 11'h000});
			r = rnd();
			i_spi_far_end.send(r[7:0], r[15:8], 8);
			repeat (8) @(posedge aclk);
			c = crc_bits(16'hffff, (m[0] && !m[1]) ? r[15:8] : r[7:0], m);
			mk = (m == 2'h1) ? 16'h007f : 16'hffff;
			c = c & mk;
			rd(spi_irq_crc_pkg::CRC_VALUE_IDX, 32'(c), 32'(mk));
			rd(spi_irq_crc_pkg::CRC_CONTROL_IDX, {m, 2'h2, m[1], c != 0, c != mk, 9'h0});
		end
		// disabled engine holds, clear loads ones, zero value flags
		wr(spi_irq_crc_pkg::CRC_CONTROL_IDX, 16'h0000);
		r = rnd();
		i_spi_far_end.send(r[7:0], r[15:8], 8);
		repeat (8) @(posedge aclk);
		rd(spi_irq_crc_pkg::CRC_VALUE_IDX, 32'(c));
		wr(spi_irq_crc_pkg::CRC_CONTROL_IDX, 16'h1000);
		rd(spi_irq_crc_pkg::CRC_VALUE_IDX, 32'hffff);
		rd(spi_irq_crc_pkg::CRC_CONTROL_IDX, 32'h0400);
		wr(spi_irq_crc_pkg::CRC_VALUE_IDX, 16'h0000);
		rd(spi_irq_crc_pkg::CRC_CONTROL_IDX, 32'h0200);
		repeat (4) @(posedge aclk);
		report_and_stop();
	end
endmodule

`default_nettype wire
